// *** verilog/rff_fifo_status.sv ***
// Contract
// - set high-level flag at nine bytes during receive
// - set low-level flag at three bytes during transmit
// - flag overflow when host overfills the fifo
// - low nibble shows unread bytes minus one
// - status bit 7 always reads zero
// - length high register holds count bits 11..4
// - length low bits 7..4 hold count 3..0
// - partial bit count used only with flag
// - low bit set marks short final byte
// - length registers zero at reset, enable low
// - length registers cleared at frame end
`timescale 1ns/10ps
`include "rff_defines.svh"

module rff_fifo_status
  import rff_pkg::*;
#(
  parameter int DEPTH = `RFF_FIFO_DEPTH,
  parameter int HIGH  = `RFF_LEVEL_HIGH,
  parameter int LOW   = `RFF_LEVEL_LOW
) (
  input  wire logic                   I_REF_CLK,
  input  wire logic                   I_RESETN,
  input  wire logic                   I_ENABLE,
  input  wire logic [`RFF_ADDR_W-1:0] I_REG_ADDR,
  input  wire logic                   I_REG_WR,
  input  wire logic                   I_REG_RD,
  input  wire logic [7:0]             I_REG_WDATA,
  input  wire logic                   I_FIFO_PUSH,
  input  wire logic                   I_FIFO_POP,
  input  wire logic                   I_RX_ACTIVE,
  input  wire logic                   I_TX_ACTIVE,
  input  wire logic                   I_TX_EOF,
  output logic [7:0]                  O_REG_RDATA,
  output logic                        O_FIFO_LEVEL_HIGH,
  output logic                        O_FIFO_LEVEL_LOW,
  output logic                        O_FIFO_OVERFLOW,
  output logic [3:0]                  O_FIFO_UNREAD,
  output logic [11:0]                 O_TX_BYTE_COUNT,
  output logic [2:0]                  O_TX_PARTIAL_BITS,
  output logic                        O_TX_PARTIAL_EN
);

  localparam logic [3:0] HIGH_LVL = 4'(HIGH);
  localparam logic [3:0] LOW_LVL  = 4'(LOW);

  rff_dir_t   dir;
  rff_dir_t   next_dir;
  logic [3:0] fill;
  logic       ovf_event;
  logic       hit_status;
  logic       hit_len_high;
  logic       hit_len_low;
  logic       status_read;
  logic       fifo_clear;
  rff_byte_t  len_high;
  rff_byte_t  len_low;
  rff_byte_t  status_word;
  logic [3:0] next_unread;
  logic [2:0] partial_bits;

  // disabling the block drops the fill bookkeeping together with the length
  assign fifo_clear = !I_ENABLE;

  // address decode
  always_comb begin
    hit_status   = 1'b0;
    hit_len_high = 1'b0;
    hit_len_low  = 1'b0;
    if (I_REG_ADDR == `RFF_OFS_FILL_STATUS) begin
      hit_status = 1'b1;
    end else if (I_REG_ADDR == `RFF_OFS_TX_LEN_HIGH) begin
      hit_len_high = 1'b1;
    end else if (I_REG_ADDR == `RFF_OFS_TX_LEN_LOW) begin
      hit_len_low = 1'b1;
    end
  end

  assign status_read = I_REG_RD && hit_status;

  rff_fill_counter #(
    .DEPTH (DEPTH),
    .CW    (4)
  ) u_fill (
    .i_clk      (I_REF_CLK),
    .i_resetn   (I_RESETN),
    .i_clear    (fifo_clear),
    .i_push     (I_FIFO_PUSH),
    .i_pop      (I_FIFO_POP),
    .o_count    (fill),
    .o_overflow (ovf_event)
  );

  // writes to the status offset have no decode target and fall away
  rff_tx_length u_txlen (
    .i_clk      (I_REF_CLK),
    .i_resetn   (I_RESETN),
    .i_enable   (I_ENABLE),
    .i_tx_eof   (I_TX_EOF),
    .i_wr_high  (I_REG_WR && hit_len_high),
    .i_wr_low   (I_REG_WR && hit_len_low),
    .i_wdata    (I_REG_WDATA),
    .o_len_high (len_high),
    .o_len_low  (len_low)
  );

  // transfer direction; transmit wins when both are claimed
  always_comb begin
    next_dir = RFF_DIR_IDLE;
    case (1'b1)
      I_TX_ACTIVE: next_dir = RFF_DIR_TX;
      I_RX_ACTIVE: next_dir = RFF_DIR_RX;
      default:     next_dir = RFF_DIR_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      dir <= RFF_DIR_IDLE;
    end else if (!I_ENABLE) begin
      dir <= RFF_DIR_IDLE;
    end else begin
      dir <= next_dir;
    end
  end

  // level flags follow the count, so they lag a fifo access by two cycles
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_FIFO_LEVEL_HIGH <= 1'b0;
    end else begin
      O_FIFO_LEVEL_HIGH <= (dir == RFF_DIR_RX) && (fill >= HIGH_LVL);
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_FIFO_LEVEL_LOW <= 1'b0;
    end else begin
      O_FIFO_LEVEL_LOW <= (dir == RFF_DIR_TX) && (fill <= LOW_LVL);
    end
  end

  // sticky until the status is read; a fresh overflow in the read cycle stays set
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_FIFO_OVERFLOW <= 1'b0;
    end else if (!I_ENABLE) begin
      O_FIFO_OVERFLOW <= 1'b0;
    end else if (ovf_event) begin
      O_FIFO_OVERFLOW <= 1'b1;
    end else if (status_read) begin
      O_FIFO_OVERFLOW <= 1'b0;
    end
  end

  // an empty fifo reads zero, the same as a single byte
  assign next_unread = (fill == 4'h0) ? 4'h0 : fill - 4'h1;

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_FIFO_UNREAD <= 4'h0;
    end else begin
      O_FIFO_UNREAD <= next_unread;
    end
  end

  always_comb begin
    status_word                                               = `RFF_STATUS_RESET;
    status_word[`RFF_STS_RESERVED_BIT]                        = 1'b0;
    status_word[`RFF_STS_HIGH_BIT]                            = O_FIFO_LEVEL_HIGH;
    status_word[`RFF_STS_LOW_BIT]                             = O_FIFO_LEVEL_LOW;
    status_word[`RFF_STS_OVF_BIT]                             = O_FIFO_OVERFLOW;
    status_word[`RFF_STS_UNREAD_MSB:`RFF_STS_UNREAD_LSB]      = O_FIFO_UNREAD;
  end

  // read data lands one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_REG_RDATA <= `RFF_RDATA_RESET;
    end else if (I_REG_RD) begin
      if (hit_status) begin
        O_REG_RDATA <= status_word;
      end else if (hit_len_high) begin
        O_REG_RDATA <= len_high;
      end else if (hit_len_low) begin
        O_REG_RDATA <= len_low;
      end else begin
        O_REG_RDATA <= `RFF_RDATA_RESET;
      end
    end
  end

  // the partial bit count is hidden unless the short-byte flag is set
  assign partial_bits = len_low[`RFF_TXL_PARTIAL_BIT] ?
                        len_low[`RFF_TXL_BITS_MSB:`RFF_TXL_BITS_LSB] : 3'h0;

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_TX_BYTE_COUNT <= 12'h000;
    end else begin
      O_TX_BYTE_COUNT <= {len_high, len_low[`RFF_TXL_COUNT_MSB:`RFF_TXL_COUNT_LSB]};
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_TX_PARTIAL_BITS <= 3'h0;
    end else begin
      O_TX_PARTIAL_BITS <= partial_bits;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_TX_PARTIAL_EN <= 1'b0;
    end else begin
      O_TX_PARTIAL_EN <= len_low[`RFF_TXL_PARTIAL_BIT];
    end
  end

endmodule

// *** verilog/rff_defines.svh ***
`ifndef RFF_DEFINES_SVH
`define RFF_DEFINES_SVH

// register offsets on the register port
`define RFF_ADDR_W           5
`define RFF_OFS_FILL_STATUS  5'h1C
`define RFF_OFS_TX_LEN_HIGH  5'h1D
`define RFF_OFS_TX_LEN_LOW   5'h1E

// fifo_fill_status fields
`define RFF_STS_RESERVED_BIT 7
`define RFF_STS_HIGH_BIT     6
`define RFF_STS_LOW_BIT      5
`define RFF_STS_OVF_BIT      4
`define RFF_STS_UNREAD_MSB   3
`define RFF_STS_UNREAD_LSB   0

// tx_length_low_partial fields
`define RFF_TXL_COUNT_MSB    7
`define RFF_TXL_COUNT_LSB    4
`define RFF_TXL_BITS_MSB     3
`define RFF_TXL_BITS_LSB     1
`define RFF_TXL_PARTIAL_BIT  0

// reset values
`define RFF_TX_LEN_RESET     8'h00
`define RFF_STATUS_RESET     8'h00
`define RFF_RDATA_RESET      8'h00

// fifo depth and fill thresholds in bytes
`define RFF_FIFO_DEPTH       12
`define RFF_LEVEL_HIGH       9
`define RFF_LEVEL_LOW        3

`endif

// *** verilog/rff_pkg.sv ***
package rff_pkg;

  typedef logic [7:0] rff_byte_t;

  typedef logic [11:0] rff_tx_count_t;

  typedef enum logic [1:0] {
    RFF_DIR_IDLE,
    RFF_DIR_RX,
    RFF_DIR_TX
  } rff_dir_t;

endpackage

// *** verilog/rff_fill_counter.sv ***
`timescale 1ns/10ps
`include "rff_defines.svh"

module rff_fill_counter
  import rff_pkg::*;
#(
  parameter int DEPTH = `RFF_FIFO_DEPTH,
  parameter int CW    = 4
) (
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  input  wire logic          i_clear,
  input  wire logic          i_push,
  input  wire logic          i_pop,
  output logic [CW-1:0]      o_count,
  output logic               o_overflow
);

  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [CW-1:0] next_count;
  logic          next_overflow;

  // a push without a pop into a full fifo is dropped and reported; a pop on empty is ignored
  always_comb begin
    next_count    = o_count;
    next_overflow = 1'b0;
    if (i_push && !i_pop) begin
      if (o_count == FULL) begin
        next_overflow = 1'b1;
      end else begin
        next_count = o_count + 1'b1;
      end
    end else if (i_pop && !i_push) begin
      if (o_count != '0) begin
        next_count = o_count - 1'b1;
      end
    end else if (i_pop && i_push && o_count == '0) begin
      next_count = o_count + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_count <= '0;
    end else if (i_clear) begin
      o_count <= '0;
    end else begin
      o_count <= next_count;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_overflow <= 1'b0;
    end else begin
      o_overflow <= next_overflow && !i_clear;
    end
  end

endmodule

// *** verilog/rff_tx_length.sv ***
`timescale 1ns/10ps
`include "rff_defines.svh"

module rff_tx_length
  import rff_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_enable,
  input  wire logic       i_tx_eof,
  input  wire logic       i_wr_high,
  input  wire logic       i_wr_low,
  input  wire logic [7:0] i_wdata,
  output rff_byte_t       o_len_high,
  output rff_byte_t       o_len_low
);

  // end of frame wins over a write in the same cycle so a stale length never survives
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_len_high <= `RFF_TX_LEN_RESET;
    end else if (!i_enable || i_tx_eof) begin
      o_len_high <= `RFF_TX_LEN_RESET;
    end else if (i_wr_high) begin
      o_len_high <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_len_low <= `RFF_TX_LEN_RESET;
    end else if (!i_enable || i_tx_eof) begin
      o_len_low <= `RFF_TX_LEN_RESET;
    end else if (i_wr_low) begin
      o_len_low <= i_wdata;
    end
  end

endmodule

// *** testbench/rff_fifo_status_assertions.sv ***
`timescale 1ns/10ps
module rff_status_assertions #(
  parameter int DEPTH = 12
) (
  input wire logic        I_REF_CLK,
  input wire logic        I_RESETN,
  input wire logic        I_ENABLE,
  input wire logic [4:0]  I_REG_ADDR,
  input wire logic        I_REG_WR,
  input wire logic        I_REG_RD,
  input wire logic [7:0]  I_REG_WDATA,
  input wire logic        I_TX_EOF,
  input wire logic [7:0]  O_REG_RDATA,
  input wire logic        O_FIFO_LEVEL_HIGH,
  input wire logic        O_FIFO_LEVEL_LOW,
  input wire logic        O_FIFO_OVERFLOW,
  input wire logic [3:0]  O_FIFO_UNREAD,
  input wire logic [11:0] O_TX_BYTE_COUNT,
  input wire logic [2:0]  O_TX_PARTIAL_BITS,
  input wire logic        O_TX_PARTIAL_EN
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);
  // a write lost to a same-cycle clear is excluded here
  sequence wr_s(logic [4:0] a);
    I_REG_WR && I_REG_ADDR == a && I_ENABLE && !I_TX_EOF;
  endsequence
  sequence rd_s(logic [4:0] a);
    I_REG_RD && I_REG_ADDR == a;
  endsequence
  rsv_zero_a: assert property (rd_s(5'h1C) |=> !O_REG_RDATA[7])
    else $error("status bit 7 read as one");
  unmapped_zero_a: assert property (rd_s(5'h00) |=> O_REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  rd_status_a: assert property (rd_s(5'h1C) |=>
    O_REG_RDATA[6:0] == {$past(O_FIFO_LEVEL_HIGH), $past(O_FIFO_LEVEL_LOW),
    $past(O_FIFO_OVERFLOW), $past(O_FIFO_UNREAD)})
    else $error("status read fields differ from outputs");
  len_high_a: assert property (wr_s(5'h1D) |-> ##2
    O_TX_BYTE_COUNT[11:4] == $past(I_REG_WDATA, 2))
    else $error("count high bits differ from write");
  len_low_a: assert property (wr_s(5'h1E) |-> ##2
    O_TX_BYTE_COUNT[3:0] == $past(I_REG_WDATA[7:4], 2) &&
    O_TX_PARTIAL_EN == $past(I_REG_WDATA[0], 2) &&
    O_TX_PARTIAL_BITS == ($past(I_REG_WDATA[0], 2) ? $past(I_REG_WDATA[3:1], 2) : 3'h0))
    else $error("count low bits or partial fields wrong");
  eof_clear_a: assert property (I_TX_EOF |-> ##2
    O_TX_BYTE_COUNT == 12'h000 && !O_TX_PARTIAL_EN && O_TX_PARTIAL_BITS == 3'h0)
    else $error("lengths not cleared at frame end");
  en_clear_a: assert property (!I_ENABLE |-> ##2 O_TX_BYTE_COUNT == 12'h000)
    else $error("lengths not cleared by enable low");
  high_lvl_a: assert property (O_FIFO_LEVEL_HIGH |->
    O_FIFO_UNREAD >= 4'h8 && !O_FIFO_LEVEL_LOW)
    else $error("high flag below nine bytes");
  low_lvl_a: assert property (O_FIFO_LEVEL_LOW |-> O_FIFO_UNREAD <= 4'h2)
    else $error("low flag above three bytes");
  ovf_full_a: assert property ($rose(O_FIFO_OVERFLOW) |-> O_FIFO_UNREAD == 4'(DEPTH - 1))
    else $error("overflow while fifo not full");
endmodule

// *** testbench/rff_host_model.sv ***
`timescale 1ns/10ps
module rff_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic [4:0]      o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic [7:0]      o_wdata,
  output logic            o_push,
  output logic            o_pop
);
  int gap = 0;
  initial begin
    {o_addr, o_wr, o_rd, o_wdata, o_push, o_pop} = '0;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d; // idle bus must not echo the last byte
    repeat (gap) @(posedge i_clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    #1;
    q = i_rdata;
    repeat (gap) @(posedge i_clk);
  endtask
  // trailing edges let the two-stage status pipeline settle
  task automatic fifo(input logic pu, input logic po, input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_push <= pu;
      o_pop  <= po;
    end
    @(posedge i_clk);
    o_push <= 1'b0;
    o_pop  <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
endmodule

// *** testbench/rfid_fifo_status_tx_length_tb.sv ***
`timescale 1ns/10ps
module rfid_fifo_status_tx_length_tb;
  logic        clk, resetn, enable, rx, tx, eof, wr, rd, push, pop, hi, lo, ovf, pen;
  logic [4:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [3:0]  unread;
  logic [11:0] cnt;
  logic [2:0]  pbits;
  int          failures = 0;
  int          check_count = 0;
  int          cyc = 0;
  rff_host_model u_rff_host_model (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata), .o_push(push), .o_pop(pop));
  rff_fifo_status u_rff_fifo_status (.I_REF_CLK(clk), .I_RESETN(resetn), .I_ENABLE(enable),
    .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata),
    .I_FIFO_PUSH(push), .I_FIFO_POP(pop), .I_RX_ACTIVE(rx), .I_TX_ACTIVE(tx),
    .I_TX_EOF(eof), .O_REG_RDATA(rdata), .O_FIFO_LEVEL_HIGH(hi), .O_FIFO_LEVEL_LOW(lo),
    .O_FIFO_OVERFLOW(ovf), .O_FIFO_UNREAD(unread), .O_TX_BYTE_COUNT(cnt),
    .O_TX_PARTIAL_BITS(pbits), .O_TX_PARTIAL_EN(pen));
  task automatic give_verdict;
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    u_rff_host_model.rd(a, q);
    chk(q, e);
  endtask
  task automatic t_len;
    u_rff_host_model.wr(5'h1D, 8'hA5);
    u_rff_host_model.wr(5'h1E, 8'h3B);
    rdc(5'h1D, 8'hA5);
    rdc(5'h1E, 8'h3B);
    chk({cnt, pbits, pen}, {12'hA53, 3'h5, 1'b1});
    u_rff_host_model.wr(5'h1E, 8'h3A);
    repeat (2) @(posedge clk);
    #1 chk({cnt, pbits, pen}, 16'hA530);
    @(posedge clk) eof <= 1'b1;
    @(posedge clk) eof <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({cnt, pbits, pen}, 16'h0000);
    rdc(5'h1D, 8'h00);
    u_rff_host_model.wr(5'h1D, 8'hFF);
    @(posedge clk) enable <= 1'b0;
    @(posedge clk) enable <= 1'b1;
    rdc(5'h1D, 8'h00);
  endtask
  task automatic t_rx;
    @(posedge clk) rx <= 1'b1;
    u_rff_host_model.fifo(1'b1, 1'b0, 8);
    rdc(5'h1C, 8'h07);
    u_rff_host_model.fifo(1'b1, 1'b0, 1);
    chk({hi, lo, ovf, unread}, 16'h0048);
    rdc(5'h1C, 8'h48);
    u_rff_host_model.wr(5'h1C, 8'hFF);
    rdc(5'h1C, 8'h48);
    u_rff_host_model.fifo(1'b1, 1'b0, 4);
    chk(ovf, 1'b1);
    rdc(5'h1C, 8'h5B);
    rdc(5'h1C, 8'h4B);
  endtask
  task automatic t_tx;
    u_rff_host_model.gap = 40;
    // receive stays claimed, so the low flag only shows if transmit wins
    @(posedge clk) tx <= 1'b1;
    u_rff_host_model.fifo(1'b0, 1'b1, 8);
    u_rff_host_model.fifo(1'b1, 1'b1, 3);
    rdc(5'h1C, 8'h03);
    u_rff_host_model.fifo(1'b0, 1'b1, 1);
    rdc(5'h1C, 8'h22);
    u_rff_host_model.fifo(1'b0, 1'b1, 4);
    rdc(5'h1C, 8'h20);
    chk({hi, lo, ovf, unread}, 16'h0020);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    // whole run needs well under two thousand cycles
    if (cyc == 6000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    {resetn, rx, tx, eof} = '0;
    enable = 1'b1;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rdc(5'h1D, 8'h00);
    rdc(5'h1E, 8'h00);
    rdc(5'h1C, 8'h00);
    rdc(5'h00, 8'h00);
    t_len();
    t_rx();
    t_tx();
    give_verdict();
  end
endmodule
bind rff_fifo_status rff_status_assertions #(.DEPTH(DEPTH)) u_chk (.*);
